// File: pspc_pkg.sv
package pspc_pkg;
   // Printed offsets are not all multiples of four: each is a register index
   localparam logic [7:0] PSPC_IDX_LINE = 8'h6A;
   localparam logic [7:0] PSPC_IDX_DIVHI = 8'h6B;
   localparam logic [7:0] PSPC_IDX_SYNC = 8'h6C;
   localparam logic [7:0] PSPC_IDX_PLL = 8'h6D;
   localparam logic [7:0] PSPC_IDX_TYPE = 8'h6E;
   localparam logic [7:0] PSPC_RST_LINE = 8'h00;
   localparam logic [7:0] PSPC_RST_DIVHI = 8'h00;
   localparam logic [7:0] PSPC_RST_SYNC = 8'h00;
   localparam logic [7:0] PSPC_RST_PLL = 8'h00;
   localparam logic [7:0] PSPC_RST_TYPE = 8'h00;
   localparam int PSPC_BIT_THERM = 7;
   localparam int PSPC_BIT_NFET = 6;
   localparam int PSPC_POS_SOFT = 4;
   localparam int PSPC_POS_ILIM = 2;
   localparam int PSPC_POS_GATE = 0;
   localparam int PSPC_BIT_SYNC_EN = 7;
   localparam int PSPC_BIT_PWM_SYNC = 6;
   localparam int PSPC_BIT_CNT_RST = 5;
   localparam int PSPC_POS_RSEL = 6;
   localparam int PSPC_BIT_SEL_DIV = 5;
   localparam int PSPC_BIT_PLL_EN = 4;
   localparam int PSPC_BIT_SYNC_TYPE = 4;
   localparam logic [7:0] PSPC_TYPE_MASK = 8'h1F;
   localparam int PSPC_CLK_HZ = 25000000;
   localparam int PSPC_SS_MS [4] = '{5, 10, 20, 50};
   localparam int PSPC_RSEL_COEF [4] = '{16, 32, 64, 128};
   localparam int PSPC_GATE_NORM_UA [4] = '{55, 110, 220, 440};
   localparam int PSPC_GATE_FAULT_UA [4] = '{300, 500, 1000, 2200};
   localparam logic [31:0] PSPC_SLVERR_DATA = 32'h00000000;
endpackage : pspc_pkg

// File: pspc_edge_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser plus rising edge pulse taken from the second stage
module pspc_edge_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic din,
   output logic level,
   output logic rise
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule : pspc_edge_sync

// File: pspc_divider.sv
`timescale 1ns/10ps
// Pulse divider: one output pulse per (div_val) input pulses, zero treated as one
module pspc_divider #(
   parameter int WIDTH = 13
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clear,
   input wire logic tick,
   input wire logic [WIDTH-1:0] div_val,
   output logic pulse
);
   logic [WIDTH-1:0] cnt_q;
   logic hit;
   assign hit = tick && (cnt_q + WIDTH'(1) >= div_val);
   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         cnt_q <= '0;
      end else if (hit) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + WIDTH'(1);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         pulse <= 1'b0;
      end else begin
         pulse <= hit;
      end
   end
endmodule : pspc_divider

// File: pspc_top.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module pspc_top #(
   parameter int DIV_WIDTH = 13,
   parameter int SS_CYCLES_MAX = 1250000
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic sync_in,
   input wire logic pwm_tick,
   input wire logic soft_start_go,
   input wire logic fault_recovery,
   output logic thermal_dimming_enable,
   output logic line_switch_type_select,
   output logic [1:0] line_current_limit_select,
   output logic [1:0] line_gate_current_select,
   output logic [11:0] gate_current_ua,
   output logic soft_start_busy,
   output logic [7:0] ramp_level,
   output logic pwm_counter_restart,
   output logic phase_detect_fb,
   output logic phase_detect_ref,
   output logic pll_enable,
   output logic pll_slow_path,
   output logic [7:0] pll_coefficient,
   output logic sync_frame_rate,
   output logic [3:0] dimming_frequency_select,
   output logic pwm_clk_from_pll
);
   logic [7:0] line_q;
   logic [7:0] divhi_q;
   logic [7:0] sync_q;
   logic [7:0] pll_q;
   logic [7:0] type_q;
   logic [9:0] word_idx;
   logic sel_ok;
   logic wr_en;
   logic sync_rise;
   logic sync_gated;
   logic pre_pulse;
   logic [DIV_WIDTH-1:0] slow_div;
   logic [31:0] ss_cnt_q;
   logic [31:0] ss_target;
   logic [31:0] ss_step;
   logic [7:0] ramp_q;

   localparam int PSPC_CLK_HZ_DIV = pspc_pkg::PSPC_CLK_HZ / 1000;

   function automatic logic [31:0] ms_to_cycles(input int ms);
      ms_to_cycles = 32'(PSPC_CLK_HZ_DIV * ms);
   endfunction : ms_to_cycles

   // Register select for one index, shared by every per-register store
   function automatic logic idx_hit(input logic [9:0] widx, input logic [7:0] idx);
      idx_hit = (widx[7:0] == idx);
   endfunction : idx_hit

   // Full 32-bit writes only touch the low lane; narrower registers sit in bits 7:0
   assign word_idx = paddr[11:2];
   assign sel_ok = (paddr[1:0] == 2'h0) && (word_idx[9:8] == 2'h0) &&
      ((word_idx[7:0] >= pspc_pkg::PSPC_IDX_LINE) && (word_idx[7:0] <= pspc_pkg::PSPC_IDX_TYPE));
   assign wr_en = psel && penable && pwrite && sel_ok && pstrb[0];

   // Zero-wait slave: answer in the first access cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // Refused accesses are flagged with the answer and never stored
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !sel_ok;
      end
   end

   // Read data stands for the access cycle only, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite && sel_ok) begin
         case (word_idx[7:0])
            pspc_pkg::PSPC_IDX_LINE: prdata <= {24'h000000, line_q};
            pspc_pkg::PSPC_IDX_DIVHI: prdata <= {24'h000000, divhi_q};
            pspc_pkg::PSPC_IDX_SYNC: prdata <= {24'h000000, sync_q};
            pspc_pkg::PSPC_IDX_PLL: prdata <= {24'h000000, pll_q};
            pspc_pkg::PSPC_IDX_TYPE: prdata <= {24'h000000, type_q};
            default: prdata <= pspc_pkg::PSPC_SLVERR_DATA;
         endcase
      end else begin
         prdata <= pspc_pkg::PSPC_SLVERR_DATA;
      end
   end

   // Each register loads only at the access edge where pready is sampled high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_q <= pspc_pkg::PSPC_RST_LINE;
      end else if (wr_en && pready && idx_hit(word_idx, pspc_pkg::PSPC_IDX_LINE)) begin
         line_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         divhi_q <= pspc_pkg::PSPC_RST_DIVHI;
      end else if (wr_en && pready && idx_hit(word_idx, pspc_pkg::PSPC_IDX_DIVHI)) begin
         divhi_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_q <= pspc_pkg::PSPC_RST_SYNC;
      end else if (wr_en && pready && idx_hit(word_idx, pspc_pkg::PSPC_IDX_SYNC)) begin
         sync_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_q <= pspc_pkg::PSPC_RST_PLL;
      end else if (wr_en && pready && idx_hit(word_idx, pspc_pkg::PSPC_IDX_PLL)) begin
         pll_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         type_q <= pspc_pkg::PSPC_RST_TYPE;
      end else if (wr_en && pready && idx_hit(word_idx, pspc_pkg::PSPC_IDX_TYPE)) begin
         type_q <= pwdata[7:0] & pspc_pkg::PSPC_TYPE_MASK;
      end
   end

   // Static configuration outputs, one register each, one cycle behind the store
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thermal_dimming_enable <= 1'b0;
      end else begin
         thermal_dimming_enable <= line_q[pspc_pkg::PSPC_BIT_THERM];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_switch_type_select <= 1'b0;
      end else begin
         line_switch_type_select <= line_q[pspc_pkg::PSPC_BIT_NFET];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_current_limit_select <= 2'h0;
      end else begin
         line_current_limit_select <= line_q[pspc_pkg::PSPC_POS_ILIM +: 2];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         line_gate_current_select <= 2'h0;
      end else begin
         line_gate_current_select <= line_q[pspc_pkg::PSPC_POS_GATE +: 2];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_enable <= 1'b0;
      end else begin
         pll_enable <= pll_q[pspc_pkg::PSPC_BIT_PLL_EN];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_slow_path <= 1'b0;
      end else begin
         pll_slow_path <= !pll_q[pspc_pkg::PSPC_BIT_SEL_DIV];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_coefficient <= 8'(pspc_pkg::PSPC_RSEL_COEF[0]);
      end else begin
         pll_coefficient <= 8'(pspc_pkg::PSPC_RSEL_COEF[pll_q[pspc_pkg::PSPC_POS_RSEL +: 2]]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_frame_rate <= 1'b0;
      end else begin
         sync_frame_rate <= type_q[pspc_pkg::PSPC_BIT_SYNC_TYPE];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dimming_frequency_select <= 4'h0;
      end else begin
         dimming_frequency_select <= type_q[3:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwm_clk_from_pll <= 1'b0;
      end else begin
         pwm_clk_from_pll <= pll_q[pspc_pkg::PSPC_BIT_PLL_EN];
      end
   end

   // Gate current: only the P-channel drive sources these currents
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gate_current_ua <= 12'h000;
      end else if (line_q[pspc_pkg::PSPC_BIT_NFET]) begin
         gate_current_ua <= 12'h000;
      end else if (fault_recovery) begin
         gate_current_ua <= 12'(pspc_pkg::PSPC_GATE_FAULT_UA[line_q[1:0]]);
      end else begin
         gate_current_ua <= 12'(pspc_pkg::PSPC_GATE_NORM_UA[line_q[1:0]]);
      end
   end

   pspc_edge_sync u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(sync_in),
      .level(),
      .rise(sync_rise)
   );
   assign sync_gated = sync_rise && sync_q[pspc_pkg::PSPC_BIT_SYNC_EN];

   // Counter restart pulse on each accepted sync rising edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwm_counter_restart <= 1'b0;
      end else begin
         pwm_counter_restart <= sync_gated && sync_q[pspc_pkg::PSPC_BIT_CNT_RST];
      end
   end

   // Pre-divider code n divides by n+1
   pspc_divider #(.WIDTH(5)) u_prediv (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(!sync_q[pspc_pkg::PSPC_BIT_SYNC_EN]),
      .tick(sync_gated),
      .div_val({1'b0, pll_q[3:0]} + 5'h01),
      .pulse(pre_pulse)
   );

   assign slow_div = {divhi_q, sync_q[4:0]};

   logic fb_pulse;
   pspc_divider #(.WIDTH(DIV_WIDTH)) u_slowdiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(!sync_q[pspc_pkg::PSPC_BIT_PWM_SYNC]),
      .tick(pwm_tick),
      .div_val(slow_div),
      .pulse(fb_pulse)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_detect_fb <= 1'b0;
      end else begin
         phase_detect_fb <= fb_pulse && sync_q[pspc_pkg::PSPC_BIT_PWM_SYNC];
      end
   end

   // Reference side of the detector: the pre-divided accepted sync
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_detect_ref <= 1'b0;
      end else begin
         phase_detect_ref <= pre_pulse && sync_q[pspc_pkg::PSPC_BIT_PWM_SYNC];
      end
   end

   // Soft-start ramp: level climbs 0..255 over the selected time
   assign ss_target = ms_to_cycles(pspc_pkg::PSPC_SS_MS[line_q[pspc_pkg::PSPC_POS_SOFT +: 2]]);
   assign ss_step = ss_target >> 8;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ss_cnt_q <= '0;
         ramp_q <= 8'h00;
         soft_start_busy <= 1'b0;
      end else if (soft_start_go && !soft_start_busy) begin
         ss_cnt_q <= '0;
         ramp_q <= 8'h00;
         soft_start_busy <= 1'b1;
      end else if (soft_start_busy) begin
         if (ss_cnt_q + 32'h1 >= ss_target) begin
            soft_start_busy <= 1'b0;
            ramp_q <= 8'hFF;
         end else begin
            ss_cnt_q <= ss_cnt_q + 32'h1;
            ramp_q <= 8'((ss_cnt_q + 32'h1) / (ss_step + 32'h1));
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ramp_level <= 8'h00;
      end else begin
         ramp_level <= ramp_q;
      end
   end
endmodule : pspc_top

// File: pspc_sync_source.sv
`timescale 1ns/10ps
// Display timing source: one sync pulse, six clocks wide, per fire request
module pspc_sync_source (
   input wire logic clk_sys,
   input wire logic fire,
   output logic sync_in
);
   // Starts idle so the synchroniser never carries an unknown into the dividers
   logic [2:0] hold_q = 3'h0;
   always_ff @(posedge clk_sys) begin
      if (fire) hold_q <= 3'h6;
      else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
   end
   // Idle low between pulses, like a real sync line
   assign sync_in = (hold_q != 3'h0);
endmodule : pspc_sync_source

// File: pspc_top_monitor.sv
`timescale 1ns/10ps
module pspc_top_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic sync_in,
   input wire logic pwm_tick,
   input wire logic fault_recovery,
   input wire logic line_switch_type_select,
   input wire logic [1:0] line_gate_current_select,
   input wire logic [11:0] gate_current_ua,
   input wire logic pwm_counter_restart,
   input wire logic phase_detect_fb,
   input wire logic pll_enable,
   input wire logic [7:0] pll_coefficient,
   input wire logic pwm_clk_from_pll
);
   localparam logic [11:0] TYPE_ADDR = {2'b00, pspc_pkg::PSPC_IDX_TYPE, 2'b00};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_ready_next; psel && !penable |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("no zero-wait answer");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
   property p_err_unmapped; psel && !penable && paddr == 12'h000 |=> pslverr && prdata == 32'h0; endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   property p_type_rsvd; pready && !pwrite && paddr == TYPE_ADDR |-> prdata[7:5] == 3'h0; endproperty
   a_type_rsvd: assert property (p_type_rsvd) else $error("reserved bits not zero");
   property p_nfet_gate; line_switch_type_select && $past(line_switch_type_select) |-> gate_current_ua == 12'h000; endproperty
   a_nfet_gate: assert property (p_nfet_gate) else $error("gate current with nfet");
   property p_gate_norm; !$past(rst) && !line_switch_type_select && !$past(fault_recovery)
      && $stable(line_gate_current_select) |-> gate_current_ua == 12'(pspc_pkg::PSPC_GATE_NORM_UA[line_gate_current_select]); endproperty
   a_gate_norm: assert property (p_gate_norm) else $error("wrong normal gate current");
   property p_coef; pll_coefficient inside {8'h10, 8'h20, 8'h40, 8'h80}; endproperty
   a_coef: assert property (p_coef) else $error("illegal coefficient");
   property p_pll_clk; pwm_clk_from_pll == pll_enable; endproperty
   a_pll_clk: assert property (p_pll_clk) else $error("pwm clock source wrong");
   property p_restart; pwm_counter_restart |-> $past(sync_in, 3) && !$past(sync_in, 4)
      ##1 !pwm_counter_restart; endproperty
   a_restart: assert property (p_restart) else $error("restart without sync edge");
   property p_fb_tick; phase_detect_fb |-> $past(pwm_tick) || $past(pwm_tick, 2); endproperty
   a_fb_tick: assert property (p_fb_tick) else $error("feedback without tick");
   c_err: cover property (pslverr);
   c_restart: cover property (pwm_counter_restart);
   c_fb: cover property (phase_detect_fb);
endmodule : pspc_top_monitor
bind pspc_top pspc_top_monitor u_mon (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pready,
   .prdata, .pslverr, .sync_in, .pwm_tick, .fault_recovery, .line_switch_type_select,
   .line_gate_current_select, .gate_current_ua, .pwm_counter_restart, .phase_detect_fb,
   .pll_enable, .pll_coefficient, .pwm_clk_from_pll);

// File: pspc_top_bench.sv
`timescale 1ns/10ps
module pspc_top_bench;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic pwm_tick = 1'b0, soft_start_go = 1'b0, fault_recovery = 1'b0, fire = 1'b0, sync_in;
   logic [11:0] paddr = 12'h000, gate_current_ua;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, thermal_dimming_enable, line_switch_type_select, soft_start_busy;
   logic pwm_counter_restart, phase_detect_fb, phase_detect_ref, pll_enable, pll_slow_path;
   logic sync_frame_rate, pwm_clk_from_pll;
   logic [1:0] line_current_limit_select, line_gate_current_select;
   logic [7:0] ramp_level, pll_coefficient;
   logic [3:0] dimming_frequency_select;
   logic [7:0] ids [5] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E};
   int n_fail = 0, n_compared = 0, n_rst = 0, n_fb = 0, n_ref = 0;
   always #20 clk_sys = ~clk_sys;
   pspc_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready,
      .prdata, .pslverr, .sync_in, .pwm_tick, .soft_start_go, .fault_recovery,
      .thermal_dimming_enable, .line_switch_type_select, .line_current_limit_select,
      .line_gate_current_select, .gate_current_ua, .soft_start_busy, .ramp_level,
      .pwm_counter_restart, .phase_detect_fb, .phase_detect_ref, .pll_enable, .pll_slow_path,
      .pll_coefficient, .sync_frame_rate, .dimming_frequency_select, .pwm_clk_from_pll);
   pspc_sync_source src (.clk_sys, .fire, .sync_in);
   always @(posedge clk_sys) begin
      n_rst += int'(pwm_counter_restart === 1'b1);
      n_fb += int'(phase_detect_fb === 1'b1);
      n_ref += int'(phase_detect_ref === 1'b1);
   end
   task automatic conclude();
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         n_fail++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {2'b00, idx, 2'b00}, d);
      // Outputs follow the store by one edge; let it pass before anyone looks
      @(posedge clk_sys);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
      check(rd, {24'h0, exp});
   endtask : rdc
   task automatic pulses(input int n);
      repeat (n) begin
         fire <= 1'b1;
         @(posedge clk_sys);
         fire <= 1'b0;
         repeat (15) @(posedge clk_sys);
      end
   endtask : pulses
   task automatic ticks(input int n);
      repeat (n) begin
         pwm_tick <= 1'b1;
         @(posedge clk_sys);
         pwm_tick <= 1'b0;
         // Feedback lands two edges on; return after the counter has seen it
         repeat (3) @(posedge clk_sys);
      end
   endtask : ticks
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (ids[i]) rdc(ids[i], 8'h00);
      wr(8'h6A, 8'hB6);
      check(32'(thermal_dimming_enable), 32'h1);
      check(32'(line_switch_type_select), 32'h0);
      check(32'(line_current_limit_select), 32'h1);
      check(32'(gate_current_ua), 32'h0DC);
      fault_recovery <= 1'b1;
      soft_start_go <= 1'b1;
      @(posedge clk_sys);
      soft_start_go <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(32'(gate_current_ua), 32'h3E8);
      check(32'(soft_start_busy), 32'h1);
      check(32'(ramp_level), 32'h0);
      fault_recovery <= 1'b0;
      wr(8'h6A, 8'h7F);
      check(32'(thermal_dimming_enable), 32'h0);
      check(32'(line_switch_type_select) | 32'(gate_current_ua), 32'h1);
      check(32'(line_current_limit_select), 32'h3);
      for (int c = 0; c < 4; c++) begin
         wr(8'h6D, {2'(c), ~c[0], c[1], 4'h5});
         check(32'(pll_coefficient), 32'h10 << c);
         check(32'(pll_slow_path), 32'(c[0]));
         check(32'({pll_enable, pwm_clk_from_pll}), 32'(c[1]) * 32'h3);
      end
      wr(8'h6E, 8'hFF);
      rdc(8'h6E, 8'h1F);
      check(32'({sync_frame_rate, dimming_frequency_select}), 32'h1F);
      wr(8'h6E, 8'hE3);
      rdc(8'h6E, 8'h03);
      check(32'({sync_frame_rate, dimming_frequency_select}), 32'h03);
      apb(1'b0, 12'h000, 8'h00);
      check({rd[31:1], err}, 32'h1);
      apb(1'b1, 12'h1A9, 8'hFF);
      check(32'(err), 32'h1);
      rdc(8'h6A, 8'h7F);
      wr(8'h6B, 8'h00);
      wr(8'h6D, 8'h01);
      wr(8'h6C, 8'hE3);
      rdc(8'h6C, 8'hE3);
      n_rst = 0;
      n_ref = 0;
      n_fb = 0;
      pulses(4);
      check(n_rst, 4);
      check(n_ref, 2);
      ticks(9);
      check(n_fb, 3);
      wr(8'h6C, 8'h63);
      n_rst = 0;
      n_ref = 0;
      pulses(2);
      check(n_rst + n_ref, 0);
      wr(8'h6C, 8'h83);
      pulses(2);
      check(n_rst, 0);
      wr(8'h6B, 8'h01);
      wr(8'h6C, 8'h40);
      rdc(8'h6B, 8'h01);
      n_fb = 0;
      ticks(64);
      check(n_fb, 2);
      conclude();
   end
endmodule : pspc_top_bench
